// ---- hdl/rrc_cfg.svh ----
// constants for the reference and regulator control registers
// assumes an 8-bit special-function register address space
`ifndef RRC_CFG_SVH
`define RRC_CFG_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define RRC_ADDR_REGULATOR_CONTROL 8'hc7
`define RRC_ADDR_REFERENCE_CONTROL 8'hd1

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RRC_BIT_REG_REF_OVERRIDE   4
`define RRC_BIT_REFERENCE_SELECT   3
`define RRC_BIT_TEMP_SENSOR_EN     2
`define RRC_BIT_STOP_REG_CONFIG    7
`define RRC_BIT_BYPASS             6
`define RRC_BIT_MEM_POWER_EN       0

// ----------------------------------------------------------------
// reset values and read values
// ----------------------------------------------------------------
`define RRC_RST_REFERENCE_CONTROL  3'h0
`define RRC_RST_REGULATOR_CONTROL  8'h00
`define RRC_READ_UNMAPPED          8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RRC_SETTLE_CLKS            20

`endif

// ---- hdl/rrc_pkg.sv ----
// types for the reference and regulator control block
// assumes rrc_cfg.svh supplies the numeric constants
package rrc_pkg;

    // converter reference source
    typedef enum logic [1:0] {
        RRC_REF_PIN       = 2'h0,
        RRC_REF_SUPPLY    = 2'h1,
        RRC_REF_REGULATOR = 2'h2
    } rrc_ref_e;

    // program memory power states, gray along gated -> settle -> on
    typedef enum logic [1:0] {
        RRC_MP_GATED  = 2'h0,
        RRC_MP_SETTLE = 2'h1,
        RRC_MP_ON     = 2'h3
    } rrc_mp_e;

endpackage : rrc_pkg

// ---- hdl/rrc_top.sv ----
// reference control and regulator control registers with memory power gating
// assumes a core on mclk issuing one-cycle sfr reads and writes,
// fetch_req and stop_mode on mclk, clk_fast from outside the domain
`timescale 1ns/1ps
`include "rrc_cfg.svh"

// What this block does
// - The reference select bit picks the external reference pin when 0 and the supply when 1.
// - The regulator override bit forces the internal regulator as reference, else the select bit decides.
// - Bit 2 of the reference register turns the temperature sensor on when 1 and off when 0.
// - Unused reference register bits 7..5 and 1..0 read as zero and writes to them are dropped.
// - With the stop config bit clear the regulator stays on in stop and every reset source works.
// - With the stop config bit set the regulator shuts down in stop and only the reset pin or power cycle resets.
// - The bypass bit set turns the regulator off and feeds the core from the supply; clear keeps it on.
// - With memory power control set and the clock slow the program memory is off in cycles with no fetch, else always on.
// - With memory power control on and the clock going fast, memory powers on and exactly 20 clocks are skipped.
module rrc_top (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    input  wire logic       stop_mode,
    input  wire logic       fetch_req,
    input  wire logic       clk_fast,
    output logic      [1:0] ref_source,
    output logic            temp_sensor_enable,
    output logic            regulator_on,
    output logic            regulator_shutdown,
    output logic            int_reset_allowed,
    output logic            mem_power_on,
    output logic            fetch_stall
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]       ref_ctl;
        logic [7:0]       reg_ctl;
        logic [7:0]       rdata;
        logic             fast_s1;
        logic             fast_s2;
        rrc_pkg::rrc_mp_e mp;
        logic [4:0]       settle;
        logic [1:0]       ref_src;
        logic             temp_en;
        logic             reg_on;
        logic             reg_shut;
        logic             rst_ok;
        logic             mem_on;
        logic             stall;
    } rrc_state_s;

    rrc_state_s s_q;
    rrc_state_s s_d;

    localparam logic [4:0] SETTLE_LAST = 5'(`RRC_SETTLE_CLKS - 1);

    wire logic wr_ref = sfr_wr && (sfr_addr == `RRC_ADDR_REFERENCE_CONTROL);
    wire logic wr_reg = sfr_wr && (sfr_addr == `RRC_ADDR_REGULATOR_CONTROL);

    always_comb begin
        logic ovr;
        logic sel;
        logic stop_regulator_config;
        logic memory_power_ctrl_enable;
        ovr    = 1'b0;
        sel    = 1'b0;
        stop_regulator_config = 1'b0;
        memory_power_ctrl_enable   = 1'b0;
        s_d    = s_q;

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        // only three bits stored
        if (wr_ref) begin
            s_d.ref_ctl = sfr_wdata[`RRC_BIT_REG_REF_OVERRIDE:`RRC_BIT_TEMP_SENSOR_EN];
        end
        if (wr_reg) begin
            s_d.reg_ctl = sfr_wdata;
        end

        // ------------------------------------------------------------
        // register reads, data held until the next read
        // ------------------------------------------------------------
        if (sfr_rd) begin
            unique case (sfr_addr)
                `RRC_ADDR_REFERENCE_CONTROL: s_d.rdata = {3'h0, s_q.ref_ctl, 2'h0};
                `RRC_ADDR_REGULATOR_CONTROL: s_d.rdata = s_q.reg_ctl;
                default:                     s_d.rdata = `RRC_READ_UNMAPPED;
            endcase
        end

        // ------------------------------------------------------------
        // reference and regulator controls
        // ------------------------------------------------------------
        ovr    = s_d.ref_ctl[`RRC_BIT_REG_REF_OVERRIDE - `RRC_BIT_TEMP_SENSOR_EN];
        sel    = s_d.ref_ctl[`RRC_BIT_REFERENCE_SELECT - `RRC_BIT_TEMP_SENSOR_EN];
        stop_regulator_config = s_d.reg_ctl[`RRC_BIT_STOP_REG_CONFIG];
        memory_power_ctrl_enable   = s_d.reg_ctl[`RRC_BIT_MEM_POWER_EN];
        if (ovr) begin
            s_d.ref_src = rrc_pkg::RRC_REF_REGULATOR;
        end else if (sel) begin
            s_d.ref_src = rrc_pkg::RRC_REF_SUPPLY;
        end else begin
            s_d.ref_src = rrc_pkg::RRC_REF_PIN;
        end
        s_d.temp_en = s_d.ref_ctl[0];
        s_d.reg_on = !s_d.reg_ctl[`RRC_BIT_BYPASS];
        s_d.reg_shut = stop_mode && stop_regulator_config;
        s_d.rst_ok   = !(stop_mode && stop_regulator_config);

        // ------------------------------------------------------------
        // program memory power
        // ------------------------------------------------------------
        s_d.fast_s1 = clk_fast;
        s_d.fast_s2 = s_q.fast_s1;
        s_d.stall   = 1'b0;
        unique case (s_q.mp)
            rrc_pkg::RRC_MP_ON: begin
                if (memory_power_ctrl_enable && !s_q.fast_s2) begin
                    s_d.mp = rrc_pkg::RRC_MP_GATED;
                end
            end
            rrc_pkg::RRC_MP_GATED: begin
                if (!memory_power_ctrl_enable) begin
                    s_d.mp = rrc_pkg::RRC_MP_ON;
                end else if (s_q.fast_s2) begin
                    s_d.mp     = rrc_pkg::RRC_MP_SETTLE;
                    s_d.settle = SETTLE_LAST;
                    s_d.stall  = 1'b1;
                end
            end
            rrc_pkg::RRC_MP_SETTLE: begin
                if (s_q.settle == 5'h0) begin
                    s_d.mp = rrc_pkg::RRC_MP_ON;
                end else begin
                    s_d.settle = s_q.settle - 5'h1;
                    s_d.stall  = 1'b1;
                end
            end
            default: begin
                s_d.mp = rrc_pkg::RRC_MP_ON;
            end
        endcase
        // gated memory on only for a fetch
        s_d.mem_on = (s_d.mp != rrc_pkg::RRC_MP_GATED) || fetch_req;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_q          <= '0;
            s_q.ref_ctl  <= `RRC_RST_REFERENCE_CONTROL;
            s_q.reg_ctl  <= `RRC_RST_REGULATOR_CONTROL;
            s_q.rdata    <= `RRC_READ_UNMAPPED;
            s_q.mp       <= rrc_pkg::RRC_MP_ON;
            s_q.ref_src  <= rrc_pkg::RRC_REF_PIN;
            s_q.reg_on   <= 1'b1;
            s_q.rst_ok   <= 1'b1;
            s_q.mem_on   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata          = s_q.rdata;
    assign ref_source         = s_q.ref_src;
    assign temp_sensor_enable = s_q.temp_en;
    assign regulator_on       = s_q.reg_on;
    assign regulator_shutdown = s_q.reg_shut;
    assign int_reset_allowed  = s_q.rst_ok;
    assign mem_power_on       = s_q.mem_on;
    assign fetch_stall        = s_q.stall;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_ref_select: assert property (wr_ref && !sfr_wdata[4] |=> ref_source == {1'b0, $past(sfr_wdata[3])})
        else $error("reference select not applied");
    a_ref_override: assert property (wr_ref && sfr_wdata[4] |=> ref_source == rrc_pkg::RRC_REF_REGULATOR)
        else $error("regulator override not applied");
    a_temp_enable: assert property (wr_ref |=> temp_sensor_enable == $past(sfr_wdata[2]))
        else $error("temperature sensor enable wrong");
    a_ref_unused: assert property (sfr_rd && sfr_addr == 8'hd1 |=>
        sfr_rdata[7:5] == 3'h0 && sfr_rdata[1:0] == 2'h0)
        else $error("unused reference bits not zero");
    a_stop_keep: assert property (!s_q.reg_ctl[7] && !wr_reg |=> int_reset_allowed && !regulator_shutdown)
        else $error("regulator shut down with stop config clear");
    a_stop_shut: assert property (s_q.reg_ctl[7] && stop_mode && !wr_reg |=>
        regulator_shutdown && !int_reset_allowed)
        else $error("regulator not shut down in stop");
    a_bypass_off: assert property (wr_reg |=> regulator_on == !$past(sfr_wdata[6]))
        else $error("bypass not reflected on regulator");
    a_mem_always: assert property (!s_q.reg_ctl[0] && !wr_reg && s_q.mp != rrc_pkg::RRC_MP_GATED |=>
        mem_power_on)
        else $error("memory powered down with controller off");
    a_settle_len: assert property ($rose(fetch_stall) |-> mem_power_on ##19 fetch_stall ##1 !fetch_stall)
        else $error("settle stall not twenty clocks");
    a_reset_vals: assert property ($rose(reset_n) |->
        ref_source == 2'h0 && !temp_sensor_enable && regulator_on && mem_power_on)
        else $error("reset values wrong");

    c_override: cover property (wr_ref && sfr_wdata[4]);
    c_settle:   cover property ($fell(fetch_stall));
    c_stop_off: cover property (regulator_shutdown);
    c_mem_gated: cover property (!mem_power_on);

endmodule : rrc_top

// ---- tb/rrc_top_tb.sv ----
// self-checking bench for the reference and regulator control block
// assumes rrc_top and rrc_cfg.svh from hdl/, inputs driven at falling mclk
`timescale 1ns/1ps
`include "rrc_cfg.svh"

module rrc_top_tb_top;
    logic       mclk = 1'b0;
    logic       reset_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic       sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sfr_rd = 1'b0;
    logic [7:0] sfr_rdata;
    logic       stop_mode = 1'b0;
    logic       fetch_req = 1'b0;
    logic       clk_fast = 1'b0;
    logic [1:0] ref_source;
    logic       temp_sensor_enable, regulator_on, regulator_shutdown;
    logic       int_reset_allowed, mem_power_on, fetch_stall;
    int         error_cnt = 0;
    int         tests_run = 0;
    int         cyc = 0;
    int         n;
    logic [7:0] rd_val;

    rrc_top DUT (.mclk(mclk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .stop_mode(stop_mode),
        .fetch_req(fetch_req), .clk_fast(clk_fast), .ref_source(ref_source),
        .temp_sensor_enable(temp_sensor_enable), .regulator_on(regulator_on),
        .regulator_shutdown(regulator_shutdown), .int_reset_allowed(int_reset_allowed),
        .mem_power_on(mem_power_on), .fetch_stall(fetch_stall));

    always #4 mclk = ~mclk;

    // ----------------------------------------------------------------
    // bus tasks and compare
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge mclk);
        sfr_rd = 1'b0;
        d      = sfr_rdata;
    endtask : rd

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t pin got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // cut a hang short
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        repeat (6) @(negedge mclk);
        reset_n = 1'b1;
        // ----------------------------------------------------------------
        // reset values
        // ----------------------------------------------------------------
        rd(`RRC_ADDR_REFERENCE_CONTROL, rd_val);
        chk(rd_val, 8'h00);
        rd(`RRC_ADDR_REGULATOR_CONTROL, rd_val);
        chk(rd_val, 8'h00);
        chk({6'h00, ref_source}, 8'h00);
        chk_bit(regulator_on, 1'b1);
        chk_bit(temp_sensor_enable, 1'b0);
        chk_bit(mem_power_on, 1'b1);
        rd(8'h55, rd_val);
        chk(rd_val, 8'h00);
        $display("test reset done");
        // ----------------------------------------------------------------
        // reference control fields
        // ----------------------------------------------------------------
        wr(`RRC_ADDR_REFERENCE_CONTROL, 8'hff);
        rd(`RRC_ADDR_REFERENCE_CONTROL, rd_val);
        chk(rd_val, 8'h1c);
        chk({6'h00, ref_source}, 8'h02);
        chk_bit(temp_sensor_enable, 1'b1);
        wr(`RRC_ADDR_REFERENCE_CONTROL, 8'he8);
        chk({6'h00, ref_source}, 8'h01);
        chk_bit(temp_sensor_enable, 1'b0);
        wr(`RRC_ADDR_REFERENCE_CONTROL, 8'h17);
        chk({6'h00, ref_source}, 8'h02);
        chk_bit(temp_sensor_enable, 1'b1);
        wr(`RRC_ADDR_REFERENCE_CONTROL, 8'h00);
        chk({6'h00, ref_source}, 8'h00);
        wr(8'hd2, 8'hff);
        rd(`RRC_ADDR_REFERENCE_CONTROL, rd_val);
        chk(rd_val, 8'h00);
        $display("test reference done");
        // ----------------------------------------------------------------
        // regulator control and stop behaviour
        // ----------------------------------------------------------------
        // reserved bits written as zero, external supply assumed for bypass
        wr(`RRC_ADDR_REGULATOR_CONTROL, 8'h41);
        rd(`RRC_ADDR_REGULATOR_CONTROL, rd_val);
        chk(rd_val, 8'h41);
        wr(`RRC_ADDR_REGULATOR_CONTROL, 8'h40);
        chk_bit(regulator_on, 1'b0);
        wr(`RRC_ADDR_REGULATOR_CONTROL, 8'h00);
        chk_bit(regulator_on, 1'b1);
        stop_mode = 1'b1;
        repeat (2) @(negedge mclk);
        chk_bit(regulator_shutdown, 1'b0);
        chk_bit(int_reset_allowed, 1'b1);
        wr(`RRC_ADDR_REGULATOR_CONTROL, 8'h80);
        @(negedge mclk);
        chk_bit(regulator_shutdown, 1'b1);
        chk_bit(int_reset_allowed, 1'b0);
        stop_mode = 1'b0;
        repeat (2) @(negedge mclk);
        chk_bit(regulator_shutdown, 1'b0);
        chk_bit(int_reset_allowed, 1'b1);
        $display("test regulator done");
        // ----------------------------------------------------------------
        // memory power gating and fast-clock settle
        // ----------------------------------------------------------------
        // controller enabled while the clock is slow
        wr(`RRC_ADDR_REGULATOR_CONTROL, 8'h01);
        repeat (3) @(negedge mclk);
        chk_bit(mem_power_on, 1'b0);
        fetch_req = 1'b1;
        @(negedge mclk);
        chk_bit(mem_power_on, 1'b1);
        fetch_req = 1'b0;
        repeat (2) @(negedge mclk);
        chk_bit(mem_power_on, 1'b0);
        clk_fast = 1'b1;
        n = 0;
        while (fetch_stall !== 1'b1 && n < 10) begin
            @(negedge mclk);
            n++;
        end
        chk(8'(n), 8'h03);
        n = 0;
        while (fetch_stall === 1'b1 && n < 40) begin
            chk_bit(mem_power_on, 1'b1);
            @(negedge mclk);
            n++;
        end
        chk(8'(n), 8'(`RRC_SETTLE_CLKS));
        chk_bit(mem_power_on, 1'b1);
        wr(`RRC_ADDR_REGULATOR_CONTROL, 8'h00);
        clk_fast = 1'b0;
        repeat (4) @(negedge mclk);
        chk_bit(mem_power_on, 1'b1);
        $display("test memory power done");
        // ----------------------------------------------------------------
        // reset in mid-run clears both registers
        // ----------------------------------------------------------------
        wr(`RRC_ADDR_REFERENCE_CONTROL, 8'h1c);
        chk({6'h00, ref_source}, 8'h02);
        wr(`RRC_ADDR_REGULATOR_CONTROL, 8'hc1);
        chk_bit(regulator_on, 1'b0);
        @(negedge mclk);
        reset_n = 1'b0;
        repeat (3) @(negedge mclk);
        reset_n = 1'b1;
        chk({6'h00, ref_source}, 8'h00);
        chk_bit(temp_sensor_enable, 1'b0);
        chk_bit(regulator_on, 1'b1);
        chk_bit(mem_power_on, 1'b1);
        chk_bit(fetch_stall, 1'b0);
        rd(`RRC_ADDR_REFERENCE_CONTROL, rd_val);
        chk(rd_val, 8'h00);
        rd(`RRC_ADDR_REGULATOR_CONTROL, rd_val);
        chk(rd_val, 8'h00);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule : rrc_top_tb_top
